// file: inc/aspm_if.sv
// the serial line between the documented port and a remote station
// each party drives one wire; the bench joins them
`timescale 1ns/1ps
interface aspm_if;
    logic dev_txd;
    logic far_txd;
    modport dev (output dev_txd, input far_txd);
    modport far (output far_txd, input dev_txd);
endinterface

// file: inc/aspm_pkg.sv
// shared constants and types of the multiprocessor serial port and its far end
// assumes a single hclk domain on both ends of the line
package aspm_pkg;
    // register indices; byte address on AHB-Lite is four times the index
    localparam logic [15:0] IDX_CCR = 16'h7050;
    localparam logic [15:0] IDX_CTL1 = 16'h7051;
    localparam logic [15:0] IDX_HBAUD = 16'h7052;
    localparam logic [15:0] IDX_LBAUD = 16'h7053;
    localparam logic [15:0] IDX_CTL2 = 16'h7054;
    localparam logic [15:0] IDX_RXST = 16'h7055;
    localparam logic [15:0] IDX_RXEMU = 16'h7056;
    localparam logic [15:0] IDX_RXBUF = 16'h7057;
    localparam logic [15:0] IDX_TXBUF = 16'h7059;
    localparam logic [15:0] IDX_PC2 = 16'h705E;
    localparam logic [15:0] IDX_PRI = 16'h705F;
    localparam logic [7:0] REG_RST = 8'h00;
    // frame_format_control fields
    localparam int CCR_LEN_LSB = 0;
    localparam int CCR_ADDR_MODE = 3;
    localparam int CCR_PAR_EN = 5;
    localparam int CCR_PAR_EVEN = 6;
    localparam int CCR_STOP2 = 7;
    // port_control_one fields
    localparam int CTL1_RX_ENA = 0;
    localparam int CTL1_TX_ENA = 1;
    localparam int CTL1_SLEEP = 2;
    localparam int CTL1_TX_WAKE = 3;
    localparam int CTL1_SW_RUN = 5;
    // port_control_two fields
    localparam int CTL2_TX_IE = 0;
    localparam int CTL2_RXBK_IE = 1;
    localparam int CTL2_TX_EMPTY = 6;
    localparam int CTL2_TX_RDY = 7;
    // receive_status fields
    localparam int RXST_WAKE = 1;
    localparam int RXST_PE = 2;
    localparam int RXST_OE = 3;
    localparam int RXST_FE = 4;
    localparam int RXST_RDY = 6;
    localparam int RXST_ERR = 7;
    // timing in sample_clock periods; wake gap and frame length in bit-times
    localparam logic [2:0] SMP_LAST = 3'd7;
    localparam logic [3:0] START_LOWS = 4'd4;
    localparam logic [2:0] VOTE_PH0 = 3'd3;
    localparam logic [2:0] VOTE_PH1 = 3'd4;
    localparam logic [2:0] VOTE_PH2 = 3'd5;
    localparam logic [6:0] IDLE_SMP = 7'd80;
    localparam logic [3:0] WAKE_GAP_BITS = 4'd11;
    localparam logic [3:0] FRAME_MAX = 4'd11;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b011, TX_PAR = 3'b010,
        TX_ADDR = 3'b110, TX_STOP = 3'b111, TX_GAP = 3'b101
    } aspm_tx_st_t;
    typedef enum logic [0:0] {RX_HUNT = 1'b0, RX_BITS = 1'b1} aspm_rx_st_t;
endpackage

// file: rtl/aspm_bitclk.sv
// sample_clock tick generator: one tick every divisor+1 clocks
// assumes divisor is stable while run is high
`timescale 1ns/1ps
module aspm_bitclk #(
    parameter int DW = 16
) (
    input wire logic hclk,          // system clock
    input wire logic hresetn,       // async reset, active low
    input wire logic run,           // hold counter at zero when low
    input wire logic [DW-1:0] divisor, // clocks per tick minus one
    output logic tick               // one-cycle pulse
);
    logic [DW-1:0] cnt_q;
    logic tick_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (!run || cnt_q == divisor) begin
            cnt_q <= '0;
            tick_q <= run;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end
    assign tick = tick_q;
endmodule

// file: rtl/aspm_dev.sv
// multiprocessor serial port: AHB-Lite register slave, transmitter, receiver
// assumes single-word AHB-Lite transfers and 8 sample_clock periods per bit
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// (R1) frame: start, 1-8 data, parity, stops
// (R2) length field gives one to eight bits
// (R3) bit 5 enables parity generate and check
// (R4) bit 6 picks odd or even parity
// (R5) bit 7 picks one or two stops
// (R6) one talker on the line at once
// (R7) sleep suppresses flags until address frame
// (R8) only software changes the sleep bit
// (R9) bit 3 picks idle-line or address-bit mode
// (R10) ten idle bit-times mark block start
// (R11) address frame wakes; irq needs enable
// (R12) receive wake flag marks address byte
// (R13) software clears sleep on own address
// (R14) idle-line mode advised for plain links
// (R15) divisor held in high and low bytes
// (R16) address bit follows data, one first
// (R17) shifter load copies then clears wake bit
// (R18) wake frame becomes eleven idle bit-times
// (R19) three-sample majority vote mid bit
// (R20) divisor bytes form sample clock divider
// (R21) reserved addresses read zero, ignore writes
module aspm_dev
    import aspm_pkg::*;
(
    input wire logic hclk,             // system clock
    input wire logic hresetn,          // async reset, active low
    input wire logic hsel,             // slave select
    input wire logic [31:0] haddr,     // byte address
    input wire logic [1:0] htrans,     // transfer type
    input wire logic hwrite,           // write when high
    input wire logic [2:0] hsize,      // word only
    input wire logic [31:0] hwdata,    // write data
    input wire logic hready,           // bus ready
    output logic [31:0] hrdata,        // read data
    output logic hreadyout,            // always ready
    output logic hresp,                // always okay
    output logic rx_irq,               // receive request, level
    output logic tx_irq,               // transmit request, level
    aspm_if.dev lnk                    // serial line
);
    typedef struct packed {
        logic [7:0] ccr, ctl1, hb, lb, pc2, pri, rxbuf, txbuf;
        logic [1:0] ie;
        logic txrdy, txempty, rdy, wake, pe, oe, fe;
        aspm_tx_st_t tst;
        logic [7:0] tsh;
        logic [3:0] tcnt;
        logic [2:0] tph;
        logic wake_shadow_flag, tpar, txd;
        aspm_rx_st_t rst;
        logic [10:0] rsh;
        logic [3:0] rcnt;
        logic [2:0] rph;
        logic [1:0] smp;
        logic [6:0] idle;
        logic blk, faddr;
        logic dph, dwr, dhit;
        logic [3:0] dreg;
        logic [31:0] rdata;
        logic rxirq, txirq;
    } aspm_dev_st_t;

    aspm_dev_st_t q, d;
    logic tick;
    logic [3:0] len, nbits;
    logic [7:0] mask;
    logic amode, paren, ap;
    logic [10:0] fr;
    logic v, is_addr;

    aspm_bitclk #(.DW(16)) u_clk (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(q.ctl1[CTL1_SW_RUN]),
        .divisor({q.hb, q.lb}),       // [R20] [R15]
        .tick(tick)
    );

    function automatic logic [7:0] rd_mux(input aspm_dev_st_t s, input logic [3:0] r);
        logic [7:0] o;
        o = 8'h00;                     // [R21]
        case (r)
            IDX_CCR[3:0]: o = s.ccr;
            IDX_CTL1[3:0]: o = s.ctl1;
            IDX_HBAUD[3:0]: o = s.hb;
            IDX_LBAUD[3:0]: o = s.lb;
            IDX_CTL2[3:0]: o = {s.txrdy, s.txempty, 4'h0, s.ie};
            IDX_RXST[3:0]: o = {s.pe | s.oe | s.fe, s.rdy, 1'b0, s.fe, s.oe, s.pe, s.wake, 1'b0};
            IDX_RXEMU[3:0], IDX_RXBUF[3:0]: o = s.rxbuf;
            IDX_TXBUF[3:0]: o = s.txbuf;
            IDX_PC2[3:0]: o = s.pc2;
            IDX_PRI[3:0]: o = s.pri;
            default: o = 8'h00;
        endcase
        return o;
    endfunction

    always_comb begin
        d = q;
        len = {1'b0, q.ccr[CCR_LEN_LSB +: 3]} + 4'd1;          // [R2]
        mask = 8'hFF >> (4'd8 - len);
        amode = q.ccr[CCR_ADDR_MODE];                             // [R9]
        paren = q.ccr[CCR_PAR_EN];                                // [R3]
        nbits = len + {3'b0, paren} + {3'b0, amode} + 4'd1;       // [R1]
        fr = '0;
        v = 1'b0;
        is_addr = 1'b0;
        // address phase: latch target; read data and read side effect now
        ap = hsel && htrans[1] && hready;
        d.dph = ap;
        if (ap) begin
            d.dwr = hwrite;
            d.dhit = (haddr[31:18] == 14'h0) && (haddr[17:6] == IDX_CCR[15:4]);
            d.dreg = haddr[5:2];
            d.rdata = '0;
            if (!hwrite && d.dhit) begin
                d.rdata = {24'h0, rd_mux(q, haddr[5:2])};
                if (haddr[5:2] == IDX_RXBUF[3:0]) begin
                    d.rdy = 1'b0;
                end
            end
        end
        // transmitter
        if (q.tst == TX_IDLE) begin
            d.txempty = q.txrdy;
            if (q.ctl1[CTL1_TX_ENA] && !q.txrdy) begin
                d.tsh = q.txbuf & mask;
                d.wake_shadow_flag = q.ctl1[CTL1_TX_WAKE];                     // [R17]
                d.ctl1[CTL1_TX_WAKE] = 1'b0;                      // [R17]
                d.txrdy = 1'b1;
                d.txempty = 1'b0;
                d.tph = '0;
                d.tcnt = '0;
                d.tpar = q.ccr[CCR_PAR_EVEN] ? ^(q.txbuf & mask) : ~^(q.txbuf & mask); // [R4]
                d.tst = (!amode && q.ctl1[CTL1_TX_WAKE]) ? TX_GAP : TX_START;        // [R18]
            end
        end else if (tick) begin
            d.tph = q.tph + 3'd1;
            if (q.tph == SMP_LAST) begin
                case (q.tst)
                    TX_START: begin
                        d.tst = TX_DATA;
                        d.tcnt = '0;
                    end
                    TX_DATA: begin
                        d.tsh = q.tsh >> 1;
                        d.tcnt = q.tcnt + 4'd1;
                        if (q.tcnt == len - 4'd1) begin
                            d.tst = paren ? TX_PAR : (amode ? TX_ADDR : TX_STOP); // [R3]
                            d.tcnt = '0;
                        end
                    end
                    TX_PAR: d.tst = amode ? TX_ADDR : TX_STOP;
                    TX_ADDR: d.tst = TX_STOP;                     // [R16]
                    TX_STOP: begin
                        if (q.ccr[CCR_STOP2] && q.tcnt == 4'd0) begin // [R5]
                            d.tcnt = 4'd1;
                        end else begin
                            d.tst = TX_IDLE;
                        end
                    end
                    TX_GAP: begin
                        d.tcnt = q.tcnt + 4'd1;
                        if (q.tcnt == WAKE_GAP_BITS - 4'd1) begin  // [R18]
                            d.tst = TX_IDLE;
                        end
                    end
                    default: d.tst = TX_IDLE;
                endcase
            end
        end
        case (d.tst)
            TX_START: d.txd = 1'b0;
            TX_DATA: d.txd = d.tsh[0];
            TX_PAR: d.txd = d.tpar;
            TX_ADDR: d.txd = d.wake_shadow_flag;                               // [R16]
            default: d.txd = 1'b1;
        endcase
        // receiver
        if (tick) begin
            case (q.rst)
                RX_HUNT: begin
                    if (!lnk.far_txd) begin
                        d.idle = '0;
                        d.rcnt = q.rcnt + 4'd1;
                        if (q.rcnt == START_LOWS - 4'd1) begin
                            d.rst = RX_BITS;
                            d.rph = VOTE_PH0;
                            d.rcnt = 4'hF;               // wraps to 0 on the start bit's vote
                            d.faddr = q.blk;                      // [R10]
                            d.blk = 1'b0;
                        end
                    end else begin
                        d.rcnt = '0;
                        if (q.idle != IDLE_SMP) begin
                            d.idle = q.idle + 7'd1;
                        end
                        if (q.idle == IDLE_SMP - 7'd1) begin
                            d.blk = 1'b1;                         // [R10]
                        end
                    end
                end
                RX_BITS: begin
                    d.rph = q.rph + 3'd1;
                    if (d.rph == VOTE_PH0) d.smp[0] = lnk.far_txd;
                    if (d.rph == VOTE_PH1) d.smp[1] = lnk.far_txd;
                    if (d.rph == VOTE_PH2) begin
                        // two of three decides the bit
                        v = (q.smp[0] & q.smp[1]) | (lnk.far_txd & (q.smp[0] | q.smp[1])); // [R19]
                        d.rsh = {v, q.rsh[10:1]};
                        d.rcnt = q.rcnt + 4'd1;
                        if (q.rcnt + 4'd1 == nbits) begin
                            fr = d.rsh >> (FRAME_MAX - nbits);
                            is_addr = amode ? fr[len + {3'b0, paren}] : q.faddr; // [R16]
                            d.rst = RX_HUNT;
                            d.rcnt = '0;
                            d.idle = '0;
                            // sleeping receiver still assembles, silent except on address frames
                            if (q.ctl1[CTL1_RX_ENA] && (!q.ctl1[CTL1_SLEEP] || is_addr)) begin // [R7]
                                d.rxbuf = fr[7:0] & mask;
                                d.oe = q.oe | d.rdy;
                                d.rdy = 1'b1;                     // [R11]
                                d.wake = is_addr;                 // [R12]
                                if (paren) begin
                                    d.pe = q.pe | (fr[len] != (q.ccr[CCR_PAR_EVEN] ?
                                        ^(fr[7:0] & mask) : ~^(fr[7:0] & mask))); // [R3] [R4]
                                end
                                d.fe = q.fe | !fr[nbits - 4'd1];
                            end
                        end
                    end
                end
                default: d.rst = RX_HUNT;
            endcase
        end
        // data phase write; sleep changes only here
        if (q.dph && q.dwr && q.dhit) begin
            case (q.dreg)
                IDX_CCR[3:0]: d.ccr = hwdata[7:0];
                IDX_CTL1[3:0]: d.ctl1 = hwdata[7:0];              // [R8]
                IDX_HBAUD[3:0]: d.hb = hwdata[7:0];               // [R15]
                IDX_LBAUD[3:0]: d.lb = hwdata[7:0];               // [R15]
                IDX_CTL2[3:0]: d.ie = hwdata[1:0];
                IDX_TXBUF[3:0]: begin
                    d.txbuf = hwdata[7:0];
                    d.txrdy = 1'b0;
                end
                IDX_PC2[3:0]: d.pc2 = hwdata[7:0];
                IDX_PRI[3:0]: d.pri = hwdata[7:0];
                default: d.pri = d.pri;                            // [R21]
            endcase
        end
        // software reset holds both machines and flags
        if (!q.ctl1[CTL1_SW_RUN]) begin
            d.tst = TX_IDLE;
            d.rst = RX_HUNT;
            d.txd = 1'b1;
            d.txrdy = 1'b1;
            d.txempty = 1'b1;
            d.rdy = 1'b0;
            d.wake = 1'b0;
            d.pe = 1'b0;
            d.oe = 1'b0;
            d.fe = 1'b0;
            d.rcnt = '0;
            d.idle = '0;
            d.blk = 1'b0;
        end
        d.rxirq = d.rdy & d.ie[CTL2_RXBK_IE];                    // [R11]
        d.txirq = d.txrdy & d.ie[CTL2_TX_IE];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.ccr <= REG_RST;
            q.ctl1 <= REG_RST;
            q.txrdy <= 1'b1;
            q.txempty <= 1'b1;
            q.txd <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hrdata = q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rx_irq = q.rxirq;
    assign tx_irq = q.txirq;
    assign lnk.dev_txd = q.txd;
endmodule

// file: rtl/aspm_far.sv
// remote station transmitter that talks to the port over the line
// assumes its format inputs match the port and stay still while busy
`timescale 1ns/1ps
module aspm_far
    import aspm_pkg::*;
(
    input wire logic hclk,             // system clock
    input wire logic hresetn,          // async reset, active low
    input wire logic [15:0] divisor,   // sample clock divider
    input wire logic [2:0] len_m1,     // data bits minus one
    input wire logic par_en,           // parity on
    input wire logic par_even,         // even parity
    input wire logic two_stop,         // two stop bits
    input wire logic addr_mode,        // address-bit mode
    input wire logic send_valid,       // frame request
    input wire logic [7:0] send_data,  // frame data
    input wire logic send_addr,        // first frame of a block
    output logic send_ready,           // request taken when high with valid
    aspm_if.far lnk                    // serial line
);
    typedef struct packed {
        aspm_tx_st_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [2:0] ph;
        logic abit, par, txd, rdy;
    } aspm_far_st_t;

    aspm_far_st_t q, d;
    logic tick;
    logic [7:0] m;

    aspm_bitclk #(.DW(16)) u_clk (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(1'b1),
        .divisor(divisor),
        .tick(tick)
    );

    always_comb begin
        d = q;
        m = 8'hFF >> (3'd7 - len_m1);
        d.rdy = 1'b0;
        if (q.st == TX_IDLE) begin
            // hold off while the port's line is low
            if (send_valid && q.rdy) begin                            // [R6]
                d.sh = send_data & m;
                d.abit = send_addr;
                d.par = par_even ? ^(send_data & m) : ~^(send_data & m);
                d.ph = '0;
                d.cnt = '0;
                d.st = (send_addr && !addr_mode) ? TX_GAP : TX_START; // [R18]
            end else begin
                d.rdy = lnk.dev_txd;                                  // [R6]
            end
        end else if (tick) begin
            d.ph = q.ph + 3'd1;
            if (q.ph == SMP_LAST) begin
                case (q.st)
                    TX_GAP: begin
                        d.cnt = q.cnt + 4'd1;
                        if (q.cnt == WAKE_GAP_BITS - 4'd1) begin
                            d.st = TX_START;
                            d.cnt = '0;
                        end
                    end
                    TX_START: d.st = TX_DATA;
                    TX_DATA: begin
                        d.sh = q.sh >> 1;
                        d.cnt = q.cnt + 4'd1;
                        if (q.cnt == {1'b0, len_m1}) begin
                            d.st = par_en ? TX_PAR : (addr_mode ? TX_ADDR : TX_STOP);
                            d.cnt = '0;
                        end
                    end
                    TX_PAR: d.st = addr_mode ? TX_ADDR : TX_STOP;
                    TX_ADDR: d.st = TX_STOP;
                    TX_STOP: begin
                        if (two_stop && q.cnt == 4'd0) begin
                            d.cnt = 4'd1;
                        end else begin
                            d.st = TX_IDLE;
                        end
                    end
                    default: d.st = TX_IDLE;
                endcase
            end
        end
        case (d.st)
            TX_START: d.txd = 1'b0;
            TX_DATA: d.txd = d.sh[0];
            TX_PAR: d.txd = d.par;
            TX_ADDR: d.txd = d.abit;                                  // [R16]
            default: d.txd = 1'b1;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.txd <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign send_ready = q.rdy;
    assign lnk.far_txd = q.txd;
endmodule

// file: testbench/aspm_line_props.sv
// line checks on both wires of the serial link
// assumes one hclk domain and divisor DIV on both ends
`timescale 1ns/1ps
module aspm_line_props #(
    parameter int DIV = 0
) (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic dev_txd, // port's serial out
    input wire logic far_txd // remote's serial out
);
    localparam int BIT = 8 * (DIV + 1);
    int dlow_q;
    int flow_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dlow_q <= 0;
            flow_q <= 0;
        end else begin
            dlow_q <= dev_txd ? 0 : dlow_q + 1;
            flow_q <= far_txd ? 0 : flow_q + 1;
        end
    end
    default clocking dflt @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // the repeat count of 7 spans a whole bit only for DIV of 0
    dev_bit_hold_a: assert property ($changed(dev_txd) |=> $stable(dev_txd)[*7])
        else $error("port bit shorter than a bit time");
    far_start_a: assert property ($fell(far_txd) |-> !far_txd[*8])
        else $error("remote start bit too short");
    dev_low_mult_a: assert property ($rose(dev_txd) |-> dlow_q % BIT == 0)
        else $error("port low run not whole bits");
    far_low_mult_a: assert property ($rose(far_txd) |-> flow_q % BIT == 0)
        else $error("remote low run not whole bits");
    dev_low_max_a: assert property (dlow_q <= 11 * BIT)
        else $error("port line low too long");
    far_low_max_a: assert property (flow_q <= 11 * BIT)
        else $error("remote line low too long");
    dev_stop_a: assert property ($rose(dev_txd) |-> dev_txd[*8])
        else $error("port stop bit too short");
    far_stop_a: assert property ($rose(far_txd) |-> far_txd[*8])
        else $error("remote stop bit too short");
    reset_idle_a: assert property ($rose(hresetn) |-> (dev_txd && far_txd))
        else $error("line not idle after reset");
endmodule

// file: testbench/async_serial_multiproc_frame_test.sv
// bench: port and remote station joined by one line
// assumes divisor 0 on both ends, so one bit is 8 clocks
`timescale 1ns/1ps
module async_serial_multiproc_frame_test;
    import aspm_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_irq, tx_irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, len_m1;
    logic par_en, par_even, two_stop, addr_mode, sv, sa, sr;
    logic [7:0] sd, d, r;
    logic [15:0] v, e;
    int errors, comparisons, n, cnt;
    logic [15:0] res [5] = '{16'h7058, 16'h705A, 16'h705B, 16'h705C, 16'h705D};
    aspm_if lnk_if();
    aspm_dev u_aspm_dev (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_irq(rx_irq), .tx_irq(tx_irq), .lnk(lnk_if));
    aspm_far u_aspm_far (.hclk(hclk), .hresetn(hresetn), .divisor(16'h0000),
        .len_m1(len_m1), .par_en(par_en), .par_even(par_even), .two_stop(two_stop),
        .addr_mode(addr_mode), .send_valid(sv), .send_data(sd), .send_addr(sa),
        .send_ready(sr), .lnk(lnk_if));
    aspm_line_props #(.DIV(0)) u_aspm_line_props (.hclk(hclk), .hresetn(hresetn),
        .dev_txd(lnk_if.dev_txd), .far_txd(lnk_if.far_txd));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t reg %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_line(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t line %h want %h", $time, got, exp);
        end
    endtask
    // one single word transfer; no wait count assumed
    task automatic ahb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        htrans <= 2'b10;
        haddr <= {14'h0000, idx, 2'b00};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata[7:0];
    endtask
    task automatic rdchk(input logic [15:0] idx, input logic [7:0] m, input logic [7:0] x);
        ahb(1'b0, idx, 8'h00);
        chk_reg(r & m, x);
    endtask
    task automatic send(input logic [7:0] dd, input logic a);
        sv <= 1'b1;
        sd <= dd;
        sa <= a;
        @(posedge hclk);
        while (sr !== 1'b1) @(posedge hclk);
        sv <= 1'b0;
        repeat (2) @(posedge hclk);
        while (sr !== 1'b1) @(posedge hclk);
    endtask
    task automatic cfg(input logic mode, input int k);
        logic [7:0] c;
        c = 8'($urandom);
        c[4] = 1'b0;
        c[3] = mode;
        // shortest and longest characters first
        if (k < 2) c[2:0] = k[0] ? 3'd7 : 3'd0;
        {two_stop, par_even, par_en} <= c[7:5];
        addr_mode <= mode;
        len_m1 <= c[2:0];
        ahb(1'b1, IDX_CCR, c);
    endtask
    function automatic logic [7:0] lmask();
        return 8'hFF >> (3'd7 - len_m1);
    endfunction
    function automatic logic [15:0] frame(input logic [7:0] dd, input logic ab);
        logic [15:0] f;
        f = 16'hFFFE;
        n = 1;
        for (int i = 0; i <= int'(len_m1); i++) begin
            f[n] = dd[i];
            n++;
        end
        if (par_en) begin
            f[n] = ^(dd & lmask()) ^ !par_even;
            n++;
        end
        if (addr_mode) begin
            f[n] = ab;
            n++;
        end
        n = n + (two_stop ? 2 : 1);
        return f;
    endfunction
    // samples each bit mid-way from the first low seen
    task automatic grab();
        v = 16'hFFFF;
        while (lnk_if.dev_txd !== 1'b0) @(posedge hclk);
        repeat (4) @(posedge hclk);
        for (int i = 0; i < n; i++) begin
            v[i] = lnk_if.dev_txd;
            repeat (8) @(posedge hclk);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge hclk);
        errors++;
        $display("BAD %0t watchdog", $time);
        print_verdict();
    end
    initial begin
        errors = 0;
        comparisons = 0;
        {hresetn, hwrite, sv, sa, par_en, par_even, two_stop, addr_mode} = '0;
        hsel = 1'b1;
        htrans = 2'b00;
        haddr = '0;
        hwdata = '0;
        hsize = 3'b010;
        len_m1 = 3'd0;
        sd = 8'h00;
        void'($urandom(32'hA19B2D2F));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(IDX_CCR, 8'hFF, REG_RST);
        rdchk(IDX_CTL1, 8'hFF, REG_RST);
        foreach (res[i]) begin
            ahb(1'b1, res[i], 8'hFF);
            rdchk(res[i], 8'hFF, 8'h00);
        end
        d = 8'($urandom);
        ahb(1'b1, IDX_HBAUD, d);
        ahb(1'b1, IDX_LBAUD, ~d);
        rdchk(IDX_HBAUD, 8'hFF, d);
        rdchk(IDX_LBAUD, 8'hFF, ~d);
        ahb(1'b1, IDX_HBAUD, 8'h00);
        ahb(1'b1, IDX_LBAUD, 8'h00);
        $display("test registers done");
        for (int k = 0; k < 8; k++) begin
            cfg(k[0], k);
            ahb(1'b1, IDX_CTL2, 8'h02);
            ahb(1'b1, IDX_CTL1, 8'h27);
            d = 8'($urandom);
            send(d, 1'b1);
            rdchk(IDX_RXST, 8'hC2, 8'h42);
            chk_reg({5'h00, hresp, tx_irq, rx_irq}, 8'h01);
            rdchk(IDX_RXBUF, 8'hFF, d & lmask());
            send(8'($urandom), 1'b0);
            rdchk(IDX_RXST, 8'h40, 8'h00);
            rdchk(IDX_CTL1, 8'hFF, 8'h27);
            ahb(1'b1, IDX_CTL1, 8'h23);
            d = 8'($urandom);
            send(d, 1'b0);
            rdchk(IDX_RXST, 8'hC2, 8'h40);
            rdchk(IDX_RXBUF, 8'hFF, d & lmask());
        end
        $display("test receive done");
        for (int k = 0; k < 6; k++) begin
            cfg(k[0], k);
            ahb(1'b1, IDX_CTL1, (k[0] & k[1]) ? 8'h2B : 8'h23);
            d = 8'($urandom);
            e = frame(d, k[0] & k[1]);
            ahb(1'b1, IDX_TXBUF, d);
            grab();
            chk_line(v, e);
            rdchk(IDX_CTL1, 8'h08, 8'h00);
        end
        $display("test transmit done");
        cfg(1'b0, 2);
        ahb(1'b1, IDX_CTL1, 8'h2B);
        ahb(1'b1, IDX_TXBUF, 8'h00);
        d = 8'($urandom);
        e = frame(d, 1'b0);
        ahb(1'b1, IDX_TXBUF, d);
        cnt = 0;
        while (lnk_if.dev_txd !== 1'b0) begin
            @(posedge hclk);
            cnt++;
        end
        chk_reg({7'h00, cnt >= 84 && cnt <= 92}, 8'h01);
        grab();
        chk_line(v, e);
        $display("test idle gap done");
        print_verdict();
    end
endmodule
